// ### psed_pkg.sv
// Purpose: shared constants for the power stage enable / delayed-off block
// Assumes: 25 MHz clock, plain register port with 8-bit address
// Notes: register offsets are byte addresses of 32-bit words
package psed_pkg;
  localparam int unsigned clk_hz = 25000000;
  localparam int unsigned delay_min_ms = 400;
  localparam int unsigned delay_max_ms = 800;
  // aim at the middle of the window so clock tolerance stays inside it
  localparam int unsigned delay_target_ms = (delay_min_ms + delay_max_ms) / 2;
  localparam int unsigned delay_cycles = (clk_hz / 1000) * delay_target_ms;
  localparam int unsigned timer_w = 24;

  localparam int unsigned addr_w = 8;
  localparam int unsigned data_w = 32;
  localparam int unsigned n_chan = 24;
  localparam int unsigned n_inj = 4;
  localparam int unsigned n_ign = 4;
  localparam int unsigned n_dd_in = 12;
  localparam int unsigned sel_w = 5;

  // channel indices
  localparam int unsigned ch_relay = 16;
  localparam int unsigned ch_bridge = 20;

  // register map
  localparam logic [7:0] adr_operation_status_one = 8'h00;
  localparam logic [7:0] adr_enable_command_register = 8'h04;
  localparam logic [7:0] adr_channel_enable_config = 8'h08;
  localparam logic [7:0] adr_control = 8'h0c;
  localparam logic [7:0] adr_direct_drive_config = 8'h10;
  localparam logic [7:0] adr_dd_assign = 8'h14;
  localparam logic [7:0] adr_output_config_fifth = 8'h18;
  localparam logic [7:0] adr_bridge_config = 8'h1c;
  localparam logic [7:0] adr_general_command_register = 8'h20;
  localparam logic [7:0] adr_outputs = 8'h24;

  // field positions
  localparam int unsigned bit_central_enable = 0;
  localparam int unsigned bit_delay_active = 1;
  localparam int unsigned bit_relay_delayed_mode = 0;
  localparam int unsigned bit_relay_open_load = 1;
  localparam int unsigned bit_relay_overcurrent = 2;
  localparam int unsigned bit_bridge_delayed_mode = 0;
  localparam int unsigned bit_bridge_freewheel = 1;
  localparam int unsigned bit_bridge_mode = 2;
  localparam int unsigned bit_delay_timer_restart = 0;
  localparam int unsigned dd_sel_per_reg = 4;

  typedef enum logic [1:0] {
    psed_idle_t_off = 2'b00,
    psed_idle_t_hold = 2'b01
  } psed_dly_state_t;
endpackage : psed_pkg

// ### psed_delay_timer.sv
// Purpose: delayed switch-off timer for one held output
// Assumes: start and restart are one-cycle pulses
// Notes: overflow is a one-cycle pulse
`timescale 1ns/10ps
module psed_delay_timer #(
  parameter int unsigned count = psed_pkg::delay_cycles
) (
  // clocking
  input wire logic clock,
  input wire logic srst,
  input wire logic clk_en,
  // control
  input wire logic start,
  input wire logic stop,
  // status
  output logic running,
  output logic overflow
);
  import psed_pkg::*;
  logic [timer_w-1:0] cnt;
  localparam logic [timer_w-1:0] last = timer_w'(count - 1);

  always_ff @(posedge clock) begin
    if (srst) begin
      cnt <= '0;
      running <= 1'b0;
      overflow <= 1'b0;
    end else if (clk_en) begin
      overflow <= 1'b0;
      if (stop) begin
        running <= 1'b0;
        cnt <= '0;
      end else if (start) begin
        running <= 1'b1;
        cnt <= '0;
      end else if (running) begin
        if (cnt == last) begin
          running <= 1'b0;
          overflow <= 1'b1;
          cnt <= '0;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end
endmodule : psed_delay_timer

// ### psed_dd_mux.sv
// Purpose: direct-drive input selection for shared outputs
// Assumes: select code 0 means unassigned, 1..n_chan picks channel code-1
// Notes: combinational
`timescale 1ns/10ps
module psed_dd_mux (
  // assignment of the four shared inputs to channels
  input wire logic [4*psed_pkg::sel_w-1:0] assign_sel,
  input wire logic [3:0] shared_in,
  // per-channel result
  output logic [psed_pkg::n_chan-1:0] dd_level,
  output logic [psed_pkg::n_chan-1:0] dd_conflict
);
  import psed_pkg::*;
  always_comb begin
    logic [2:0] hits;
    hits = 3'h0;
    dd_level = '0;
    dd_conflict = '0;
    for (int c = 0; c < n_chan; c++) begin
      hits = 3'h0;
      for (int k = 0; k < 4; k++) begin
        if (assign_sel[k*sel_w +: sel_w] == sel_w'(c + 1)) begin
          hits = hits + 3'h1;
          dd_level[c] = dd_level[c] | shared_in[k];
        end
      end
      // two inputs on one output: keep it off
      dd_conflict[c] = (hits > 3'h1);
    end
  end
endmodule : psed_dd_mux

// ### psed_top.sv
// Purpose: power stage enable and delayed switch-off control
// Assumes: protection, supply monitors and serial link supply levels
// Notes: channel 16 is the relay output, channel 20 the bridge output
// Notes on behaviour
// - central enable readable and command-writable
// - per-channel enable, cleared by protection
// - set ignored while protection active
// - central enable 1 sets unprotected enables
// - central enable 0 clears all enables
// - injector/ignition gated by group pins
// - battery overvoltage forces all stages off
// - delayed-mode bit per relay and bridge
// - trigger holds on output; normal mode off
// - supply, timeout, monitor, reset pin trigger
// - hold only if on; no switch-on meanwhile (code blocks stage_on only; ign_on can still switch on)
// - restart bit restarts the delay timer
// - listed events end delayed-off
// - power-on reset drops held outputs
// - sleep entry ends delayed-off
// - delayed config survives undervoltage/reset-pin reset
// - on by control bit or direct input
// - doubly assigned direct drive keeps off
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/10ps
module psed_top (
  // clocking
  input wire logic clock,
  input wire logic srst,
  input wire logic clk_en,
  // register port
  input wire logic [psed_pkg::addr_w-1:0] reg_addr,
  input wire logic [psed_pkg::data_w-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [psed_pkg::data_w-1:0] reg_rdata,
  // channel inputs
  input wire logic [psed_pkg::n_chan-1:0] frame_on,
  input wire logic [psed_pkg::n_chan-1:0] protect_active,
  input wire logic [psed_pkg::n_dd_in-1:0] dd_in,
  input wire logic [psed_pkg::n_ign-1:0] ign_ctrl,
  input wire logic injector_group_enable_pin,
  input wire logic ignition_group_enable_pin,
  // supervisory conditions
  input wire logic bat_overvoltage,
  input wire logic supply_undervoltage,
  input wire logic supply_overvoltage,
  input wire logic link_timeout,
  input wire logic monitor_pin,
  input wire logic reset_pin,
  input wire logic ready_state,
  input wire logic sleep_request,
  // stage drives
  output logic [psed_pkg::n_chan-1:0] stage_on,
  output logic [psed_pkg::n_ign-1:0] ign_on,
  output logic delay_active
);
  import psed_pkg::*;

  logic central_enable;
  logic [n_chan-1:0] chan_enable;
  logic [n_chan-1:0] ctrl_bits;
  logic [n_chan-1:0] dd_select;
  logic [4*sel_w-1:0] dd_assign;
  logic [2:0] relay_cfg;
  logic [2:0] bridge_cfg;
  logic [n_chan-1:0] dd_level;
  logic [n_chan-1:0] dd_conflict;
  logic [n_chan-1:0] next_stage_on;
  logic [n_ign-1:0] next_ign_on;
  logic trigger;
  logic trigger_q;
  logic soft_reset;
  logic keep_cfg;
  logic restart;
  logic relay_start;
  logic bridge_start;
  logic relay_hold;
  logic bridge_hold;
  logic relay_end;
  logic bridge_end;
  logic relay_run;
  logic bridge_run;
  logic relay_ovf;
  logic bridge_ovf;
  logic wr_cmd_oe;
  logic wr_chan_en;

  // supply-undervoltage/reset-pin events act as a partial register reset
  assign trigger = supply_undervoltage | supply_overvoltage | link_timeout |
                   ~monitor_pin | ~reset_pin;
  assign soft_reset = supply_undervoltage | ~reset_pin;
  assign keep_cfg = relay_cfg[bit_relay_delayed_mode] |
                    bridge_cfg[bit_bridge_delayed_mode];
  assign restart = reg_wr && reg_addr == adr_general_command_register &&
                   reg_wdata[bit_delay_timer_restart];
  assign wr_cmd_oe = reg_wr && reg_addr == adr_enable_command_register;
  assign wr_chan_en = reg_wr && reg_addr == adr_channel_enable_config;

  function automatic logic is_mask_bit(input int unsigned c);
    return c == ch_relay || c == ch_bridge;
  endfunction : is_mask_bit

  // central enable
  always_ff @(posedge clock) begin
    if (srst) begin
      central_enable <= 1'b0;
    end else if (clk_en) begin
      if (wr_cmd_oe) begin
        central_enable <= reg_wdata[bit_central_enable];
      end else if (soft_reset && !keep_cfg) begin
        central_enable <= 1'b0;
      end
    end
  end

  // per-channel enables
  always_ff @(posedge clock) begin
    if (srst) begin
      chan_enable <= '0;
    end else if (clk_en) begin
      for (int c = 0; c < n_chan; c++) begin
        if (protect_active[c]) begin
          chan_enable[c] <= 1'b0;
        end else if (wr_cmd_oe) begin
          chan_enable[c] <= reg_wdata[bit_central_enable];
        end else if (wr_chan_en) begin
          chan_enable[c] <= reg_wdata[c];
        end else if (soft_reset && !(keep_cfg && is_mask_bit(c))) begin
          chan_enable[c] <= 1'b0;
        end
      end
    end
  end

  // control and configuration bits
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_bits <= '0;
      dd_select <= '0;
      dd_assign <= '0;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == adr_control) begin
        ctrl_bits <= reg_wdata[n_chan-1:0];
      end else if (soft_reset) begin
        // held outputs keep their on bit, or the hold would end at once
        for (int c = 0; c < n_chan; c++) begin
          if (!(keep_cfg && is_mask_bit(c))) begin
            ctrl_bits[c] <= 1'b0;
          end
        end
      end
      if (reg_wr && reg_addr == adr_direct_drive_config) begin
        dd_select <= reg_wdata[n_chan-1:0];
      end else if (soft_reset) begin
        dd_select <= '0;
      end
      if (reg_wr && reg_addr == adr_dd_assign) begin
        dd_assign <= reg_wdata[4*sel_w-1:0];
      end else if (soft_reset) begin
        dd_assign <= '0;
      end
    end
  end

  // delayed-mode configuration
  always_ff @(posedge clock) begin
    if (srst) begin
      relay_cfg <= '0;
      bridge_cfg <= '0;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == adr_output_config_fifth) begin
        relay_cfg <= reg_wdata[2:0];
      end else if (soft_reset && !keep_cfg) begin
        relay_cfg <= '0;
      end
      if (reg_wr && reg_addr == adr_bridge_config) begin
        bridge_cfg <= reg_wdata[2:0];
      end else if (soft_reset && !keep_cfg) begin
        bridge_cfg <= '0;
      end
    end
  end

  psed_dd_mux u_dd_mux (
    .assign_sel(dd_assign),
    .shared_in(dd_in[n_dd_in-1:n_dd_in-4]),
    .dd_level(dd_level),
    .dd_conflict(dd_conflict)
  );

  // end conditions for each held output
  assign relay_end = relay_ovf || !central_enable || !ctrl_bits[ch_relay] ||
                     !chan_enable[ch_relay] ||
                     !relay_cfg[bit_relay_delayed_mode] ||
                     (ready_state && !trigger) || sleep_request;
  assign bridge_end = bridge_ovf || !central_enable ||
                      !ctrl_bits[ch_bridge] || !chan_enable[ch_bridge] ||
                      !bridge_cfg[bit_bridge_delayed_mode] ||
                      (ready_state && !trigger) || sleep_request;

  assign relay_start = trigger && !trigger_q && stage_on[ch_relay];
  assign bridge_start = trigger && !trigger_q && stage_on[ch_bridge];

  psed_delay_timer u_relay_timer (
    .clock(clock),
    .srst(srst),
    .clk_en(clk_en),
    .start(relay_start || (restart && relay_run)),
    .stop(relay_end),
    .running(relay_run),
    .overflow(relay_ovf)
  );

  psed_delay_timer u_bridge_timer (
    .clock(clock),
    .srst(srst),
    .clk_en(clk_en),
    .start(bridge_start || (restart && bridge_run)),
    .stop(bridge_end),
    .running(bridge_run),
    .overflow(bridge_ovf)
  );

  // start cycle counts too, else the trigger drops the output first
  assign relay_hold = relay_cfg[bit_relay_delayed_mode] &&
                      (relay_run || relay_start);
  assign bridge_hold = bridge_cfg[bit_bridge_delayed_mode] &&
                       (bridge_run || bridge_start);

  always_ff @(posedge clock) begin
    if (srst) begin
      trigger_q <= 1'b0;
    end else if (clk_en) begin
      trigger_q <= trigger;
    end
  end

  // stage drive
  always_comb begin
    logic want;
    want = 1'b0;
    next_stage_on = '0;
    for (int c = 0; c < n_chan; c++) begin
      want = (dd_select[c] ? (dd_level[c] && !dd_conflict[c])
                           : ctrl_bits[c]);
      if (c < n_inj) begin
        want = want && injector_group_enable_pin;
      end
      // no new switch-on while a delayed-off is in progress
      if ((relay_run || bridge_run) && !stage_on[c]) begin
        want = 1'b0;
      end
      if (trigger) begin
        want = 1'b0;
      end
      next_stage_on[c] = want && chan_enable[c] && central_enable &&
                         !bat_overvoltage;
    end
    if (relay_hold && !relay_end && stage_on[ch_relay]) begin
      next_stage_on[ch_relay] = !bat_overvoltage;
    end
    if (bridge_hold && !bridge_end && stage_on[ch_bridge]) begin
      next_stage_on[ch_bridge] = !bat_overvoltage;
    end
    next_ign_on = ign_ctrl & {n_ign{ignition_group_enable_pin &&
                  central_enable && !bat_overvoltage && !trigger}};
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      stage_on <= '0;
      ign_on <= '0;
      delay_active <= 1'b0;
    end else if (clk_en) begin
      stage_on <= next_stage_on;
      ign_on <= next_ign_on;
      delay_active <= relay_hold || bridge_hold;
    end
  end

  // register read port
  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= '0;
      if (reg_rd) begin
        unique case (reg_addr)
          adr_operation_status_one: begin
            reg_rdata[bit_central_enable] <= central_enable;
            reg_rdata[bit_delay_active] <= delay_active;
          end
          adr_channel_enable_config: reg_rdata[n_chan-1:0] <= chan_enable;
          adr_control: reg_rdata[n_chan-1:0] <= ctrl_bits;
          adr_direct_drive_config: reg_rdata[n_chan-1:0] <= dd_select;
          adr_dd_assign: reg_rdata[4*sel_w-1:0] <= dd_assign;
          adr_output_config_fifth: reg_rdata[2:0] <= relay_cfg;
          adr_bridge_config: reg_rdata[2:0] <= bridge_cfg;
          adr_outputs: reg_rdata[n_chan-1:0] <= stage_on;
          default: reg_rdata <= '0;
        endcase
      end
    end
  end
endmodule : psed_top

// ### psed_top_asserts.sv
// Purpose: port checks for psed_top
// Assumes: one clock, srst synchronous active high
// Notes: channels 16 and 20 are the only ones a hold may keep on
`timescale 1ns/10ps
module psed_top_asserts (
  // clocking
  input wire logic clock,
  input wire logic srst,
  // observed ports
  input wire logic reg_rd,
  input wire logic [psed_pkg::data_w-1:0] reg_rdata,
  input wire logic [psed_pkg::n_chan-1:0] stage_on,
  input wire logic [psed_pkg::n_ign-1:0] ign_on,
  input wire logic delay_active,
  input wire logic injector_group_enable_pin,
  input wire logic ignition_group_enable_pin,
  input wire logic bat_overvoltage,
  input wire logic supply_undervoltage,
  input wire logic supply_overvoltage,
  input wire logic link_timeout,
  input wire logic monitor_pin,
  input wire logic reset_pin,
  input wire logic ready_state,
  input wire logic sleep_request
);
  import psed_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  logic trig;
  assign trig = supply_undervoltage | supply_overvoltage | link_timeout |
                !monitor_pin | !reset_pin;
  sequence s_hold_gone;
    ##[1:2] !delay_active;
  endsequence
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data without a read");
  property p_inj_gate;
    !injector_group_enable_pin |=> stage_on[3:0] == 4'h0;
  endproperty
  a_inj_gate: assert property (p_inj_gate)
    else $error("injector on with group pin low");
  property p_ign_gate;
    !ignition_group_enable_pin |=> ign_on == 4'h0;
  endproperty
  a_ign_gate: assert property (p_ign_gate)
    else $error("ignition on with group pin low");
  property p_bat_off;
    bat_overvoltage |=> stage_on == '0;
  endproperty
  a_bat_off: assert property (p_bat_off)
    else $error("stage on during battery overvoltage");
  property p_trig_off;
    trig |=> (stage_on & 24'heeffff) == '0;
  endproperty
  a_trig_off: assert property (p_trig_off)
    else $error("unheld stage on during trigger");
  property p_ready_end;
    delay_active && ready_state && !trig |-> s_hold_gone;
  endproperty
  a_ready_end: assert property (p_ready_end)
    else $error("hold kept in ready state");
  property p_sleep_end;
    delay_active && sleep_request |-> s_hold_gone;
  endproperty
  a_sleep_end: assert property (p_sleep_end)
    else $error("hold kept on sleep entry");
  property p_por_off;
    $fell(srst) |-> stage_on == '0 && !delay_active;
  endproperty
  a_por_off: assert property (p_por_off)
    else $error("output on after reset");
endmodule : psed_top_asserts

// ### psed_mcu.sv
// Purpose: controller model on the register port
// Assumes: tasks are entered just after a rising edge
// Notes: a gap cycle follows each strobe, slower than needed
`timescale 1ns/10ps
module psed_mcu (
  // clocking
  input wire logic clock,
  // register port
  output logic [psed_pkg::addr_w-1:0] reg_addr,
  output logic [psed_pkg::data_w-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  import psed_pkg::*;
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
  endtask : rd
  // bridge mode bit stays 0: single switch only
  task automatic cfg_delayed;
    wr(adr_direct_drive_config, 32'h0);
    wr(adr_output_config_fifth, 32'h1);
    wr(adr_bridge_config, 32'h1);
  endtask : cfg_delayed
endmodule : psed_mcu

// ### psed_top_tb.sv
// Purpose: self-checking bench for psed_top
// Assumes: every check but the direct ign_on compare is a register read, so one queue covers those
// Notes: the 600 ms timer cannot be shortened at the top, overflow untested
`timescale 1ns/10ps
module psed_top_tb;
  import psed_pkg::*;
  typedef struct {
    logic [31:0] e;
    logic [31:0] m;
    string n;
  } psed_exp_t;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd;
  logic [23:0] protect_active = '0, stage_on, prot;
  logic [11:0] dd_in = '0;
  logic [3:0] ign_ctrl = '0, ign_on;
  logic inj_pin = 1'b0, ign_pin = 1'b0, bat_ov = 1'b0, uv = 1'b0;
  logic ov = 1'b0, tmo = 1'b0, mon = 1'b1, rstp = 1'b1;
  logic ready = 1'b0, sleep = 1'b0, delay_active, rd_seen = 1'b0;
  logic ce = 1'b1;
  psed_exp_t exp_q[$];
  int err_total = 0;
  int num_checks = 0;
  psed_mcu u_mcu (.clock(clock), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  psed_top DUT (.clock(clock), .srst(srst), .clk_en(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_on(24'h0),
    .protect_active(protect_active), .dd_in(dd_in), .ign_ctrl(ign_ctrl),
    .injector_group_enable_pin(inj_pin),
    .ignition_group_enable_pin(ign_pin), .bat_overvoltage(bat_ov),
    .supply_undervoltage(uv), .supply_overvoltage(ov),
    .link_timeout(tmo), .monitor_pin(mon), .reset_pin(rstp),
    .ready_state(ready), .sleep_request(sleep), .stage_on(stage_on),
    .ign_on(ign_on), .delay_active(delay_active));
  initial begin
    forever #20 clock = ~clock;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle
  task automatic chk(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m, input string n);
    exp_q.push_back('{e, m, n});
    u_mcu.rd(a);
  endtask : chk
  task automatic set_trig(input int i, input logic v);
    case (i)
      0: tmo <= v;
      1: ov <= v;
      2: mon <= !v;
      3: uv <= v;
      default: rstp <= !v;
    endcase
  endtask : set_trig
  task give_verdict;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  // compare off the edge, where read data has settled
  always @(negedge clock) begin
    psed_exp_t x;
    if (rd_seen) begin
      x = exp_q.pop_front();
      num_checks++;
      if ((reg_rdata & x.m) !== (x.e & x.m)) begin
        err_total++;
        $display("[FAIL] %s expected %h seen %h", x.n, x.e & x.m,
                 reg_rdata & x.m);
      end
    end
    rd_seen = reg_rd;
  end
  initial begin
    idle(5000);
    err_total++;
    give_verdict();
  end
  initial begin
    void'($urandom(16377));
    idle(4);
    srst <= 1'b0;
    prot = $urandom & 24'heeffd0;
    protect_active <= prot;
    dd_in <= 12'($urandom & 32'hff);
    ign_ctrl <= 4'($urandom);
    idle(1);
    chk(adr_operation_status_one, 32'h0, '1, "status");
    chk(adr_outputs, 32'h0, '1, "stages");
    chk(8'h3c, 32'h0, '1, "unmapped");
    u_mcu.wr(adr_enable_command_register, 32'h1);
    chk(adr_operation_status_one, 32'h1, 32'h1, "central");
    chk(adr_channel_enable_config, ~prot, 32'hffffff, "enables");
    u_mcu.wr(adr_control, 32'hffffff);
    idle(2);
    chk(adr_outputs, ~prot & 24'hfffff0, '1, "inj low");
    inj_pin <= 1'b1;
    ign_pin <= 1'b1;
    idle(2);
    chk(adr_outputs, ~prot, 32'hffffff, "inj high");
    num_checks++;
    if (ign_on !== ign_ctrl) begin
      err_total++;
      $display("[FAIL] ign_on expected %h seen %h", ign_ctrl, ign_on);
    end
    bat_ov <= 1'b1;
    idle(2);
    chk(adr_outputs, 32'h0, '1, "bat");
    bat_ov <= 1'b0;
    protect_active <= '0;
    idle(2);
    chk(adr_channel_enable_config, ~prot, 32'hffffff, "kept off");
    chk(adr_outputs, ~prot, 32'hffffff, "diag first");
    chk(adr_outputs, ~prot, 32'hffffff, "diag again");
    u_mcu.wr(adr_enable_command_register, 32'h1);
    chk(adr_channel_enable_config, 32'hffffff, '1, "all on");
    u_mcu.wr(adr_enable_command_register, 32'h0);
    idle(1);
    chk(adr_channel_enable_config, 32'h0, '1, "cleared");
    chk(adr_outputs, 32'h0, '1, "all off");
    u_mcu.wr(adr_enable_command_register, 32'h1);
    u_mcu.wr(adr_control, 32'h0);
    u_mcu.wr(adr_direct_drive_config, 32'h20);
    u_mcu.wr(adr_dd_assign, 32'h6);
    dd_in[8] <= 1'b1;
    idle(2);
    chk(adr_outputs, 32'h20, 32'h20, "direct");
    u_mcu.wr(adr_dd_assign, 32'hc6);
    idle(2);
    chk(adr_outputs, 32'h0, 32'h20, "double");
    u_mcu.cfg_delayed();
    for (int i = 0; i < 5; i++) begin
      u_mcu.wr(adr_enable_command_register, 32'h1);
      u_mcu.wr(adr_control, 32'h110001);
      idle(2);
      set_trig(i, 1'b1);
      idle(3);
      chk(adr_operation_status_one, 32'h3, 32'h3, "hold");
      chk(adr_outputs, 32'h110000, '1, "held");
      if (i >= 3) begin
        chk(adr_channel_enable_config, '1, 32'h110000, "kept en");
        chk(adr_output_config_fifth, 32'h1, 32'h1, "kept cfg");
        chk(adr_operation_status_one, 32'h1, 32'h1, "kept oe");
      end
      if (i == 0) begin
        u_mcu.wr(adr_general_command_register, 32'h1);
        chk(adr_operation_status_one, 32'h2, 32'h2, "restart");
        u_mcu.wr(adr_control, 32'h100000);
        idle(2);
        chk(adr_outputs, 32'h100000, '1, "one ends");
      end
      set_trig(i, 1'b0);
      if (i % 2 == 1) begin
        sleep <= 1'b1;
      end else begin
        ready <= 1'b1;
      end
      idle(3);
      sleep <= 1'b0;
      ready <= 1'b0;
      chk(adr_operation_status_one, 32'h0, 32'h2, "ended");
    end
    ce <= 1'b0;
    u_mcu.wr(adr_enable_command_register, 32'h0);
    ce <= 1'b1;
    chk(adr_outputs, 32'h110000, '1, "frozen");
    set_trig(0, 1'b1);
    idle(3);
    srst <= 1'b1;
    idle(4);
    srst <= 1'b0;
    set_trig(0, 1'b0);
    idle(1);
    chk(adr_outputs, 32'h0, '1, "por");
    chk(adr_operation_status_one, 32'h0, '1, "por status");
    idle(2);
    give_verdict();
  end
endmodule : psed_top_tb
bind psed_top psed_top_asserts u_chk (.clock(clock), .srst(srst),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stage_on(stage_on),
  .ign_on(ign_on), .delay_active(delay_active),
  .injector_group_enable_pin(injector_group_enable_pin),
  .ignition_group_enable_pin(ignition_group_enable_pin),
  .bat_overvoltage(bat_overvoltage),
  .supply_undervoltage(supply_undervoltage),
  .supply_overvoltage(supply_overvoltage), .link_timeout(link_timeout),
  .monitor_pin(monitor_pin), .reset_pin(reset_pin),
  .ready_state(ready_state), .sleep_request(sleep_request));
